// ===== logic/lsc_map.svh
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define LSC_ADDR_W 4
`define LSC_OFS_IND 4'h0
`define LSC_OFS_UNLOCK 4'h4

// ****************************************************************
// indicator_select_control fields
// ****************************************************************
`define LSC_BIT_STATE 15
`define LSC_BIT_POL 14
`define LSC_BIT_OFF 13
`define LSC_BIT_FAST 12
`define LSC_BIT_WAKE 9
`define LSC_BIT_DUPLEX 8
`define LSC_BIT_TX 4
`define LSC_BIT_RX 2
`define LSC_IND_WR_MASK 16'h7314
`define LSC_IND_RST 16'h1014

// ****************************************************************
// unlock register fields
// ****************************************************************
`define LSC_BIT_UNLOCK 12
`define LSC_UNLOCK_RST 1'h0

// ****************************************************************
// network condition inputs
// ****************************************************************
`define LSC_COND_W 7

`endif

// ===== logic/lsc_pkg.sv
package lsc_pkg;

  typedef logic [31:0] lsc_word_t;
  typedef logic [15:0] lsc_half_t;

  // index of each sampled network condition
  typedef enum logic [2:0] {
    LSC_C_TX,
    LSC_C_RX,
    LSC_C_FAST,
    LSC_C_WAKE_MODE,
    LSC_C_WAKE_SEEN,
    LSC_C_LINK_PASS,
    LSC_C_FULL_DUPLEX
  } lsc_cond_idx_t;

endpackage : lsc_pkg

// ===== logic/lsc_cond_sample.sv
`timescale 1ns/10ps
`include "lsc_map.svh"

module lsc_cond_sample
  import lsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`LSC_COND_W-1:0] cond_i,
  output logic [`LSC_COND_W-1:0] cond_o
);

  logic [`LSC_COND_W-1:0] nxt_cond;
  logic [`LSC_COND_W-1:0] cond_ff;

  // ****************************************************************
  // one flop per condition, same clock as the mac core
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `LSC_COND_W; gi = gi + 1)
    begin : g_cond
      always_comb
      begin
        nxt_cond[gi] = rst_i ? 1'h0 : cond_i[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    cond_ff <= nxt_cond;
  end

  assign cond_o = cond_ff;

endmodule : lsc_cond_sample

// ===== logic/lsc_top.sv
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "lsc_map.svh"


module lsc_top
  import lsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic stop_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`LSC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_act_i,
  input wire logic rx_act_i,
  input wire logic speed_100_i,
  input wire logic wake_mode_en_i,
  input wire logic wake_frame_seen_i,
  input wire logic link_pass_i,
  input wire logic full_duplex_i,
  output logic indicator_state_bit_o,
  output logic led_o,
  output logic led_oe_o
);

  // ****************************************************************
  // condition sampling
  // ****************************************************************
  logic [`LSC_COND_W-1:0] cond_raw;
  logic [`LSC_COND_W-1:0] cond_q;

  assign cond_raw[LSC_C_TX] = tx_act_i;
  assign cond_raw[LSC_C_RX] = rx_act_i;
  assign cond_raw[LSC_C_FAST] = speed_100_i;
  assign cond_raw[LSC_C_WAKE_MODE] = wake_mode_en_i;
  assign cond_raw[LSC_C_WAKE_SEEN] = wake_frame_seen_i;
  assign cond_raw[LSC_C_LINK_PASS] = link_pass_i;
  assign cond_raw[LSC_C_FULL_DUPLEX] = full_duplex_i;

  lsc_cond_sample u_sample (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(cond_raw),
    .cond_o(cond_q)
  );

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  logic ack_ff;
  logic nxt_ack;
  lsc_word_t rdat_ff;
  lsc_word_t nxt_rdat;
  logic req;
  logic hit_ind;
  logic hit_unlock;
  logic wr_ind;
  logic wr_unlock;

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign hit_ind = (wb_adr_i == `LSC_OFS_IND);
  assign hit_unlock = (wb_adr_i == `LSC_OFS_UNLOCK);
  assign wr_ind = req & wb_we_i & hit_ind;
  assign wr_unlock = req & wb_we_i & hit_unlock;

  // ****************************************************************
  // registers
  // ****************************************************************
  lsc_half_t cfg_ff;
  lsc_half_t nxt_cfg;
  logic unlock_ff;
  logic nxt_unlock;
  logic state_ff;
  logic nxt_state;
  logic pin_ff;
  logic nxt_pin;
  logic pin_oe_ff;
  logic nxt_pin_oe;
  logic [4:0] terms;
  logic [4:0] ens;
  lsc_half_t wr_bits;
  lsc_half_t wr_lanes;

  always_comb
  begin
    wr_lanes = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & `LSC_IND_WR_MASK;
    wr_bits = wb_dat_i[15:0] & `LSC_IND_WR_MASK;
    nxt_cfg = cfg_ff;
    nxt_unlock = unlock_ff;
    // soft reset and stop are deliberately not looked at here
    if (rst_i)
    begin
      nxt_cfg = `LSC_IND_RST;
      nxt_unlock = `LSC_UNLOCK_RST;
    end
    else
    begin
      if (wr_ind && unlock_ff)
      begin
        // state and reserved bits never stored
        nxt_cfg = (cfg_ff & ~wr_lanes) | (wr_bits & wr_lanes);
      end
      if (wr_unlock && wb_sel_i[1])
      begin
        nxt_unlock = wb_dat_i[`LSC_BIT_UNLOCK];
      end
    end
  end

  always_comb
  begin
    nxt_ack = rst_i ? 1'h0 : req;
    nxt_rdat = 32'h0;
    if (req && !wb_we_i && hit_ind)
    begin
      // upper half returned as zero, one legal undefined value
      nxt_rdat[15:0] = cfg_ff;
      nxt_rdat[`LSC_BIT_STATE] = state_ff;
    end
    else if (req && !wb_we_i && hit_unlock)
    begin
      nxt_rdat[`LSC_BIT_UNLOCK] = unlock_ff;
    end
  end

  // ****************************************************************
  // combined state and pin
  // ****************************************************************
  always_comb
  begin
    terms[0] = cond_q[LSC_C_TX];
    terms[1] = cond_q[LSC_C_RX];
    terms[2] = cond_q[LSC_C_FAST];
    terms[3] = cond_q[LSC_C_WAKE_MODE] & cond_q[LSC_C_WAKE_SEEN];
    terms[4] = cond_q[LSC_C_LINK_PASS] & cond_q[LSC_C_FULL_DUPLEX];
    ens = {cfg_ff[`LSC_BIT_DUPLEX], cfg_ff[`LSC_BIT_WAKE],
           cfg_ff[`LSC_BIT_FAST], cfg_ff[`LSC_BIT_RX], cfg_ff[`LSC_BIT_TX]};
    // polarity is not an input of the state
    nxt_state = rst_i ? 1'h0 : |(terms & ens);
    nxt_pin = 1'h0;
    nxt_pin_oe = 1'h0;
    if (rst_i || cfg_ff[`LSC_BIT_OFF])
    begin
      nxt_pin = 1'h0;
      nxt_pin_oe = 1'h0;
    end
    else if (cfg_ff[`LSC_BIT_POL])
    begin
      nxt_pin = nxt_state;
      nxt_pin_oe = 1'h1;
    end
    else
    begin
      // pulls low only, external pull-up gives the high
      nxt_pin = 1'h0;
      nxt_pin_oe = nxt_state;
    end
  end

  always_ff @(posedge clk_i)
  begin
    cfg_ff <= nxt_cfg;
    unlock_ff <= nxt_unlock;
    ack_ff <= nxt_ack;
    rdat_ff <= nxt_rdat;
    state_ff <= nxt_state;
    pin_ff <= nxt_pin;
    pin_oe_ff <= nxt_pin_oe;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign indicator_state_bit_o = state_ff;
  assign led_o = pin_ff;
  assign led_oe_o = pin_oe_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [4:0] raw_terms;
  logic past_ok;
  logic past_ok_nxt;

  assign raw_terms = {link_pass_i & full_duplex_i,
                      wake_mode_en_i & wake_frame_seen_i,
                      speed_100_i, rx_act_i, tx_act_i};
  assign past_ok_nxt = ~rst_i;

  always_ff @(posedge clk_i)
  begin
    past_ok <= past_ok_nxt;
  end

  property p_state_or;
    past_ok && $past(past_ok)
      |-> state_ff == |($past(raw_terms, 2) & $past(ens));
  endproperty
  a_state_or: assert property (p_state_or)
    else $error("state bit is not the or of enabled terms");

  property p_state_ro;
    (ens == 5'h0) [*2] |-> !state_ff;
  endproperty
  a_state_ro: assert property (p_state_ro)
    else $error("state bit high with nothing enabled");

  property p_resv_zero;
    req && !wb_we_i |=> wb_dat_o[31:16] == 16'h0
      && wb_dat_o[11:10] == 2'h0 && wb_dat_o[3] == 1'h0;
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved bits read back nonzero");

  property p_resv_read;
    wb_ack_o && $past(!wb_we_i && hit_ind)
      |-> wb_dat_o[11:10] == 2'h0 && wb_dat_o[3] == 1'h0;
  endproperty
  a_resv_read: assert property (p_resv_read)
    else $error("reserved bits not zero on read");

  property p_totem;
    past_ok && $past(cfg_ff[`LSC_BIT_POL] && !cfg_ff[`LSC_BIT_OFF])
      |-> led_oe_o && led_o == state_ff;
  endproperty
  a_totem: assert property (p_totem)
    else $error("totem pole pin does not follow state");

  property p_open_drain;
    past_ok && $past(!cfg_ff[`LSC_BIT_POL] && !cfg_ff[`LSC_BIT_OFF])
      |-> !led_o && led_oe_o == state_ff;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin not inverse of state");

  property p_off;
    past_ok && $past(cfg_ff[`LSC_BIT_OFF]) |-> !led_oe_o && !led_o;
  endproperty
  a_off: assert property (p_off)
    else $error("pin driven while output is off");

  property p_fast;
    past_ok && $past(past_ok) && $past(speed_100_i, 2)
      && $past(cfg_ff[`LSC_BIT_FAST]) |-> state_ff;
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast speed term missing");

  property p_wake;
    past_ok && $past(past_ok)
      && $past(wake_mode_en_i && wake_frame_seen_i, 2)
      && $past(cfg_ff[`LSC_BIT_WAKE]) |-> state_ff;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake frame term missing");

  property p_duplex_only;
    past_ok && $past(past_ok) && $past(ens == 5'h10) |->
      state_ff == $past(link_pass_i && full_duplex_i, 2);
  endproperty
  a_duplex_only: assert property (p_duplex_only)
    else $error("duplex link term wrong");

  property p_rx;
    past_ok && $past(past_ok) && $past(rx_act_i, 2)
      && $past(cfg_ff[`LSC_BIT_RX]) |-> state_ff;
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive term missing");

  property p_tx;
    past_ok && $past(past_ok) && $past(tx_act_i, 2)
      && $past(cfg_ff[`LSC_BIT_TX]) |-> state_ff;
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit term missing");

  property p_hard_reset;
    !past_ok |-> cfg_ff == `LSC_IND_RST && !unlock_ff;
  endproperty
  a_hard_reset: assert property (p_hard_reset)
    else $error("fields wrong after hard reset");

  property p_soft_keep;
    (soft_rst_i || stop_i) && !wr_ind |=> $stable(cfg_ff);
  endproperty
  a_soft_keep: assert property (p_soft_keep)
    else $error("soft reset or stop changed fields");

  property p_locked;
    wr_ind && !unlock_ff |=> $stable(cfg_ff) ##1 $stable(cfg_ff);
  endproperty
  a_locked: assert property (p_locked)
    else $error("write taken while locked");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held more than one cycle");

  c_totem_lit: cover property (led_oe_o && led_o);
  c_drain_lit: cover property (led_oe_o && !led_o);
  c_locked_wr: cover property (wr_ind && !unlock_ff);
  c_unlocked_wr: cover property (wr_ind && unlock_ff ##2 state_ff);

endmodule : lsc_top

// ===== testbench/lsc_led_model.sv
`timescale 1ns/10ps

module lsc_led_model
(
  input wire logic drive_i,
  input wire logic drive_en_i,
  output logic pin_o,
  output logic lit_o
);
  // released pin rests on the pull-up, never on a stale value
  assign pin_o = drive_en_i ? drive_i : 1'b1;
  // led hangs from the supply, so it lights while sunk low
  assign lit_o = ~pin_o;
endmodule : lsc_led_model

// ===== testbench/tb.sv
`timescale 1ns/10ps
`include "lsc_map.svh"

module tb
  import lsc_pkg::*;
  ;
  logic clk_i, rst_i, soft_rst_i, stop_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0] wb_adr_i, wb_sel_i;
  lsc_word_t wb_dat_i, wb_dat_o;
  logic wb_ack_o, state_o, led_o, led_oe_o, pin, unlock;
  logic [6:0] cond;
  lsc_half_t cfg;
  lsc_half_t rd_q[$];
  logic [2:0] ind_q[$];
  event ind_ev;
  integer seed = 73;
  int fails = 0;
  int num_checks = 0;

  lsc_top u_lsc_top (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .stop_i(stop_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_act_i(cond[LSC_C_TX]), .rx_act_i(cond[LSC_C_RX]),
    .speed_100_i(cond[LSC_C_FAST]), .wake_mode_en_i(cond[LSC_C_WAKE_MODE]),
    .wake_frame_seen_i(cond[LSC_C_WAKE_SEEN]),
    .link_pass_i(cond[LSC_C_LINK_PASS]),
    .full_duplex_i(cond[LSC_C_FULL_DUPLEX]),
    .indicator_state_bit_o(state_o), .led_o(led_o), .led_oe_o(led_oe_o));

  lsc_led_model u_lsc_led_model (.drive_i(led_o), .drive_en_i(led_oe_o),
    .pin_o(pin), .lit_o());

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // expectations
  // ****************************************************************
  function automatic logic exp_state();
    exp_state = (cond[LSC_C_TX] & cfg[`LSC_BIT_TX])
      | (cond[LSC_C_RX] & cfg[`LSC_BIT_RX])
      | (cond[LSC_C_FAST] & cfg[`LSC_BIT_FAST])
      | (cond[LSC_C_WAKE_MODE] & cond[LSC_C_WAKE_SEEN] & cfg[`LSC_BIT_WAKE])
      | (cond[LSC_C_LINK_PASS] & cond[LSC_C_FULL_DUPLEX]
         & cfg[`LSC_BIT_DUPLEX]);
  endfunction : exp_state

  // {state, drive enable, wire level}
  function automatic logic [2:0] exp_ind();
    logic s;
    s = exp_state();
    if (cfg[`LSC_BIT_OFF])
      exp_ind = {s, 2'b01};
    else if (cfg[`LSC_BIT_POL])
      exp_ind = {s, 1'b1, s};
    else
      exp_ind = {s, s, ~s};
  endfunction : exp_ind

  task automatic hard_reset_model();
    cfg = 16'h0;
    cfg[`LSC_BIT_TX] = 1'b1;
    cfg[`LSC_BIT_RX] = 1'b1;
    cfg[`LSC_BIT_FAST] = 1'b1;
    unlock = 1'b0;
  endtask : hard_reset_model

  // ****************************************************************
  // comparisons
  // ****************************************************************
  task automatic cmp_rd(input lsc_half_t got, input lsc_half_t exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_ind(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t indicator %b expected %b", $time, got, exp);
    end
  endtask : cmp_ind

  // upper half is undefined on reads, so only bits 15-0 are judged
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i)
      if (rd_q.size() == 0)
        cmp_rd(wb_dat_o[15:0], 16'hXXXX);
      else
        cmp_rd(wb_dat_o[15:0], rd_q.pop_front());

  always @(ind_ev)
    cmp_ind({state_o, led_oe_o, pin}, ind_q.pop_front());

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic wb(input logic we, input logic [3:0] adr,
                    input lsc_word_t d, input logic [3:0] sel);
    int n;
    lsc_half_t lm;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    n = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50)
    begin
      fails++;
      $display("ERROR %0t no bus acknowledge", $time);
      conclude();
    end
    lm = {{8{sel[1]}}, {8{sel[0]}}} & `LSC_IND_WR_MASK;
    if (we && adr == `LSC_OFS_IND && unlock)
      cfg = (cfg & ~lm) | (d[15:0] & lm);
    if (we && adr == `LSC_OFS_UNLOCK && sel[1])
      unlock = d[`LSC_BIT_UNLOCK];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [3:0] adr);
    lsc_half_t e;
    e = 16'h0;
    if (adr == `LSC_OFS_IND)
      e = {exp_state(), cfg[14:0]};
    if (adr == `LSC_OFS_UNLOCK)
      e[`LSC_BIT_UNLOCK] = unlock;
    rd_q.push_back(e);
    wb(1'b0, adr, 32'h0, 4'hF);
  endtask : rd

  task automatic chk_ind();
    repeat (3) @(posedge clk_i);
    ind_q.push_back(exp_ind());
    -> ind_ev;
  endtask : chk_ind

  task automatic post_reset();
    repeat (3) @(posedge clk_i);
    rd(`LSC_OFS_IND);
    rd(`LSC_OFS_UNLOCK);
    rd(4'h8);
    wb(1'b1, `LSC_OFS_IND, 32'h0000_6300, 4'hF);
    rd(`LSC_OFS_IND);
    chk_ind();
  endtask : post_reset

  task automatic conclude();
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    rst_i = 1'b1;
    {soft_rst_i, stop_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h00;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    cond = 7'h00;
    hard_reset_model();
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    post_reset();
    wb(1'b1, `LSC_OFS_UNLOCK, 32'h0000_1000, 4'hF);
    // random enables, lanes, soft reset and stop; reserved bits 11, 10 and 3 held at zero
    repeat (80)
    begin
      cond <= 7'($random(seed));
      soft_rst_i <= 1'($random(seed));
      stop_i <= 1'($random(seed));
      // software keeps the upper half and reserved bits at zero
      wb(1'b1, `LSC_OFS_IND, $random(seed) & 32'h0000_F3F7,
         4'($random(seed)));
      chk_ind();
      rd(`LSC_OFS_IND);
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    hard_reset_model();
    post_reset();
    conclude();
  end
endmodule : tb
